/* File: hw/lpsc_pkg.sv */
// Package for the low-power sensing configuration bank: offsets, field positions, types.
// Assumes a 16-bit register word port addressed by 16-bit word offsets.
package lpsc_pkg;
  // Register word offsets; each register spans consecutive 16-bit words
  localparam logic [15:0] LPSC_OFS_SETTINGS  = 16'h11C0;
  localparam logic [15:0] LPSC_OFS_SETUP_LO  = 16'h11C2;
  localparam logic [15:0] LPSC_OFS_SETUP_HI  = 16'h11C3;
  localparam logic [15:0] LPSC_OFS_TXM_W0    = 16'h11C6;
  localparam logic [15:0] LPSC_OFS_TXM_W1    = 16'h11C7;
  localparam logic [15:0] LPSC_OFS_TXM_W2    = 16'h11C8;
  // Writable bit masks; zero bits are unused and read as zero
  localparam logic [15:0] LPSC_SETTINGS_MASK = 16'hF0FF;
  localparam logic [31:0] LPSC_SETUP_MASK    = 32'hF3FFFFFF;
  localparam logic [47:0] LPSC_TXM_MASK      = 48'h2FFFFFFFFFFF;
  // Reset values
  localparam logic [15:0] LPSC_SETTINGS_RST  = 16'h0000;
  localparam logic [31:0] LPSC_SETUP_RST     = 32'h00000000;
  localparam logic [47:0] LPSC_TXM_RST       = 48'h000000000000;
  // Field positions in the settings word
  localparam int LPSC_SW_EN_BIT   = 15;
  localparam int LPSC_SW_POL_BIT  = 14;
  localparam int LPSC_PTRIM_LSB   = 12;
  localparam int LPSC_MOSC_LSB    = 6;
  localparam int LPSC_LP2_EN_BIT  = 5;
  localparam int LPSC_LP1_EN_BIT  = 4;
  localparam int LPSC_LP2_CYC_LSB = 2;
  localparam int LPSC_LP1_CYC_LSB = 0;
  // Field positions in the setup word
  localparam int LPSC_ALT_EN_BIT  = 31;
  localparam int LPSC_FILT_BIT    = 30;
  localparam int LPSC_MUTUAL_BIT  = 29;
  localparam int LPSC_SHIELD_BIT  = 28;
  // Auto-prox cycle counts per code
  localparam logic [8:0] LPSC_CYC_16  = 9'h010;
  localparam logic [8:0] LPSC_CYC_32  = 9'h020;
  localparam logic [8:0] LPSC_CYC_64  = 9'h040;
  localparam logic [8:0] LPSC_CYC_256 = 9'h100;

  typedef enum logic [1:0] {LPSC_OSC_14M, LPSC_OSC_20M, LPSC_OSC_24M, LPSC_OSC_BAD} lpsc_osc_t;

  // Register access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } lpsc_req_t;

  // Decoded configuration towards the sensing engine
  typedef struct packed {
    logic       switch_active;
    lpsc_osc_t  main_osc;
    logic       main_osc_valid;
    logic [1:0] prox_trim_code;
    logic [5:0] prox_trim_pct;
    logic       lp1_autoprox_en;
    logic       lp2_autoprox_en;
    logic [8:0] lp1_cycles;
    logic [8:0] lp2_cycles;
    logic       alt_channel_en;
    logic       count_filter_en;
    logic       mutual_sense;
    logic       tx_shield;
    logic       ground_unused;
    logic [25:0] rx_mask;
    logic [47:0] tx_mask;
  } lpsc_cfg_t;
endpackage : lpsc_pkg

/* File: hw/lpsc_bank.sv */
// Configuration register bank for low-power sensing: switch, oscillators, auto-prox, alt channel.
// Assumes the serial host interface delivers single-cycle word strobes on clk.
`timescale 1ns/1ps
// How it works
// - Switch input is used only when enabled; bit 14 selects its active level.
// - Bits 13-12 trim the prox oscillator; reduction depends on main oscillator.
// - Bits 7-6 pick main oscillator 14, 20 or 24 MHz; code 11 undefined.
// - Bit 5 enables autonomous prox scanning in second low-power mode.
// - Bit 4 enables autonomous prox scanning in first low-power mode.
// - Bits 3-2 give second-mode prox cycles 16, 32, 64 or 256.
// - Bits 1-0 give first-mode prox cycles 16, 32, 64 or 256.
// - Bit 31 senses the alternate channel in low-power modes, else trackpad.
// - Bit 30 enables the count filter on the alternate channel count.
// - Bit 29 chooses self (0) or mutual (1) alternate sensing.
// - In self mode bit 28 shields selected transmitters, else grounds unused electrodes.
// - Bits 25-0 select receive electrodes for the alternate sensor.
// - Transmit mask bits 45 and 43-0 select transmit electrodes.
module lpsc_bank import lpsc_pkg::*; (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire lpsc_req_t  req,
  input  wire logic       switch_pin,
  output logic [15:0]     rdata,
  output logic            rvalid,
  output logic            switch_pressed,
  output lpsc_cfg_t       cfg
);
  logic [15:0] settings_ff, nxt_settings;
  logic [31:0] setup_ff, nxt_setup;
  logic [47:0] txm_ff, nxt_txm;
  logic [15:0] rdata_ff, nxt_rdata;
  logic        rvalid_ff, nxt_rvalid;
  logic        sw_s1_ff, sw_s2_ff, sw_out_ff, nxt_sw_out;
  lpsc_cfg_t   cfg_ff, nxt_cfg;

  // Code to cycle count, shared by both low-power modes
  function automatic logic [8:0] cyc_of(input logic [1:0] code);
    case (code)
      2'h0:    cyc_of = LPSC_CYC_16;
      2'h1:    cyc_of = LPSC_CYC_32;
      2'h2:    cyc_of = LPSC_CYC_64;
      default: cyc_of = LPSC_CYC_256;
    endcase
  endfunction : cyc_of

  // Ten percent per trim step as eight times the code plus two times the code, so no multiplier is needed
  function automatic logic [5:0] pct_of(input logic [1:0] code);
    pct_of = {1'h0, code, 3'h0} + {3'h0, code, 1'b0};
  endfunction : pct_of

  // Register writes; masks drop unused bits so they always read back as zero
  always_comb begin
    nxt_settings = settings_ff;
    nxt_setup    = setup_ff;
    nxt_txm      = txm_ff;
    if (req.wr) begin
      case (req.addr)
        LPSC_OFS_SETTINGS: nxt_settings = req.wdata & LPSC_SETTINGS_MASK;
        LPSC_OFS_SETUP_LO: nxt_setup[15:0] = req.wdata;
        LPSC_OFS_SETUP_HI: nxt_setup[31:16] = req.wdata & LPSC_SETUP_MASK[31:16];
        LPSC_OFS_TXM_W0:   nxt_txm[15:0] = req.wdata;
        LPSC_OFS_TXM_W1:   nxt_txm[31:16] = req.wdata;
        // Bit 44 is masked too, so a careless host cannot select it
        LPSC_OFS_TXM_W2:   nxt_txm[47:32] = req.wdata & LPSC_TXM_MASK[47:32];
        default: ;
      endcase
    end
  end

  // Read port: one cycle latency, unmapped words read zero
  always_comb begin
    nxt_rvalid = req.rd;
    nxt_rdata  = 16'h0000;
    if (req.rd) begin
      case (req.addr)
        LPSC_OFS_SETTINGS: nxt_rdata = settings_ff;
        LPSC_OFS_SETUP_LO: nxt_rdata = setup_ff[15:0];
        LPSC_OFS_SETUP_HI: nxt_rdata = setup_ff[31:16];
        LPSC_OFS_TXM_W0:   nxt_rdata = txm_ff[15:0];
        LPSC_OFS_TXM_W1:   nxt_rdata = txm_ff[31:16];
        LPSC_OFS_TXM_W2:   nxt_rdata = txm_ff[47:32];
        default:           nxt_rdata = 16'h0000;
      endcase
    end
  end

  // Switch gating and polarity on the synchronised pin
  always_comb begin
    nxt_sw_out = settings_ff[LPSC_SW_EN_BIT] &
                 (sw_s2_ff ~^ settings_ff[LPSC_SW_POL_BIT]);
  end

  // Decode of the configuration toward the sensing engine
  always_comb begin
    nxt_cfg = '0;
    nxt_cfg.switch_active   = settings_ff[LPSC_SW_EN_BIT];
    nxt_cfg.main_osc        = lpsc_osc_t'(settings_ff[LPSC_MOSC_LSB +: 2]);
    nxt_cfg.main_osc_valid  = (settings_ff[LPSC_MOSC_LSB +: 2] != 2'h3);
    nxt_cfg.prox_trim_code  = settings_ff[LPSC_PTRIM_LSB +: 2];
    // Percent reduction: 10 per step at 14 MHz, one extra step at faster clocks
    // The undefined oscillator code takes the fast-clock column rather than a third one
    if (settings_ff[LPSC_PTRIM_LSB +: 2] == 2'h0)
      nxt_cfg.prox_trim_pct = 6'h00;
    else if (settings_ff[LPSC_MOSC_LSB +: 2] == 2'h0)
      nxt_cfg.prox_trim_pct = pct_of(settings_ff[LPSC_PTRIM_LSB +: 2]);
    else
      nxt_cfg.prox_trim_pct = pct_of(settings_ff[LPSC_PTRIM_LSB +: 2]) + 6'h0A;
    nxt_cfg.lp2_autoprox_en = settings_ff[LPSC_LP2_EN_BIT];
    nxt_cfg.lp1_autoprox_en = settings_ff[LPSC_LP1_EN_BIT];
    nxt_cfg.lp2_cycles      = cyc_of(settings_ff[LPSC_LP2_CYC_LSB +: 2]);
    nxt_cfg.lp1_cycles      = cyc_of(settings_ff[LPSC_LP1_CYC_LSB +: 2]);
    nxt_cfg.alt_channel_en  = setup_ff[LPSC_ALT_EN_BIT];
    nxt_cfg.count_filter_en = setup_ff[LPSC_FILT_BIT];
    nxt_cfg.mutual_sense    = setup_ff[LPSC_MUTUAL_BIT];
    // Shield only matters for self sensing
    nxt_cfg.tx_shield       = ~setup_ff[LPSC_MUTUAL_BIT] & setup_ff[LPSC_SHIELD_BIT];
    nxt_cfg.ground_unused   = ~setup_ff[LPSC_MUTUAL_BIT] & ~setup_ff[LPSC_SHIELD_BIT];
    nxt_cfg.rx_mask         = setup_ff[25:0];
    nxt_cfg.tx_mask         = txm_ff & LPSC_TXM_MASK;
  end

  // State registers; pin passes two flops before use
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settings_ff <= LPSC_SETTINGS_RST;
      setup_ff    <= LPSC_SETUP_RST;
      txm_ff      <= LPSC_TXM_RST;
      rdata_ff    <= 16'h0000;
      rvalid_ff   <= 1'b0;
      sw_s1_ff    <= 1'b0;
      sw_s2_ff    <= 1'b0;
      sw_out_ff   <= 1'b0;
      cfg_ff      <= '0;
    end else begin
      settings_ff <= nxt_settings;
      setup_ff    <= nxt_setup;
      txm_ff      <= nxt_txm;
      rdata_ff    <= nxt_rdata;
      rvalid_ff   <= nxt_rvalid;
      sw_s1_ff    <= switch_pin;
      sw_s2_ff    <= sw_s1_ff;
      sw_out_ff   <= nxt_sw_out;
      cfg_ff      <= nxt_cfg;
    end
  end

  assign rdata          = rdata_ff;
  assign rvalid         = rvalid_ff;
  assign switch_pressed = sw_out_ff;
  assign cfg            = cfg_ff;

  // Settings word: switch, oscillators and auto-prox decode, one edge behind the register
  switch_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    !settings_ff[LPSC_SW_EN_BIT] |=> !switch_pressed)
    else $error("switch reported while disabled");
  switch_level_a: assert property (@(posedge clk) disable iff (!nrst)
    settings_ff[LPSC_SW_EN_BIT] && settings_ff[LPSC_SW_POL_BIT] && sw_s2_ff |=> switch_pressed)
    else $error("active-high switch not reported");
  trim_nominal_a: assert property (@(posedge clk) disable iff (!nrst)
    settings_ff[13:12] == 2'h0 |=> cfg.prox_trim_pct == 6'h00)
    else $error("nominal trim not zero");
  trim_slow_a: assert property (@(posedge clk) disable iff (!nrst)
    settings_ff[13:12] == 2'h3 && settings_ff[7:6] == 2'h0 |=> cfg.prox_trim_pct == 6'h1E)
    else $error("slow-clock trim wrong");
  trim_fast_a: assert property (@(posedge clk) disable iff (!nrst)
    settings_ff[13:12] == 2'h2 && settings_ff[7:6] == 2'h1 |=> cfg.prox_trim_pct == 6'h1E)
    else $error("fast trim wrong");
  osc_sel_a: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> cfg.main_osc_valid == ($past(settings_ff[7:6]) != 2'h3))
    else $error("oscillator valid wrong");
  lp2_en_a: assert property (@(posedge clk) disable iff (!nrst)
    req.wr && req.addr == LPSC_OFS_SETTINGS ##1 1'b1
    |=> cfg.lp2_autoprox_en == $past(req.wdata[5], 2))
    else $error("lp2 enable mismatch");
  lp1_en_a: assert property (@(posedge clk) disable iff (!nrst)
    req.wr && req.addr == LPSC_OFS_SETTINGS ##1 1'b1
    |=> cfg.lp1_autoprox_en == $past(req.wdata[4], 2))
    else $error("lp1 enable mismatch");
  lp2_cyc_a: assert property (@(posedge clk) disable iff (!nrst)
    settings_ff[3:2] == 2'h3 |=> cfg.lp2_cycles == 9'h100)
    else $error("lp2 cycles wrong");
  lp2_cyc_mid_a: assert property (@(posedge clk) disable iff (!nrst)
    settings_ff[3:2] == 2'h2 |=> cfg.lp2_cycles == 9'h040)
    else $error("lp2 middle cycles wrong");
  lp1_cyc_a: assert property (@(posedge clk) disable iff (!nrst)
    settings_ff[1:0] == 2'h1 |=> cfg.lp1_cycles == 9'h020)
    else $error("lp1 cycles wrong");
  lp1_cyc_min_a: assert property (@(posedge clk) disable iff (!nrst)
    settings_ff[1:0] == 2'h0 |=> cfg.lp1_cycles == 9'h010)
    else $error("lp1 minimum cycles wrong");

  // Alternate channel setup decode
  alt_en_a: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> cfg.alt_channel_en == $past(setup_ff[31]))
    else $error("alt enable mismatch");
  filt_en_a: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> cfg.count_filter_en == $past(setup_ff[LPSC_FILT_BIT]))
    else $error("count filter enable mismatch");
  sense_method_a: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> cfg.mutual_sense == $past(setup_ff[LPSC_MUTUAL_BIT]))
    else $error("sensing method mismatch");
  shield_mode_a: assert property (@(posedge clk) disable iff (!nrst)
    !(cfg.tx_shield && (cfg.mutual_sense || cfg.ground_unused)))
    else $error("shield in wrong mode");
  rx_mask_a: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> cfg.rx_mask == $past(setup_ff[25:0]))
    else $error("receive mask mismatch");

  // Transmit mask, unused bits and read port
  tx_mask_a: assert property (@(posedge clk) disable iff (!nrst)
    req.wr && req.addr == LPSC_OFS_TXM_W0 ##1 1'b1 |=> cfg.tx_mask[15:0] == $past(req.wdata, 2))
    else $error("transmit mask low word mismatch");
  unused_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    settings_ff[11:8] == 4'h0 && setup_ff[27:26] == 2'h0 && txm_ff[47:44] ==? 4'b00?0)
    else $error("unused bit set");
  rd_valid_a: assert property (@(posedge clk) disable iff (!nrst)
    req.rd |=> rvalid)
    else $error("read not answered");
  rd_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    !req.rd |=> !rvalid && rdata == 16'h0000)
    else $error("read port busy without a read");
  unmapped_rd_a: assert property (@(posedge clk) disable iff (!nrst)
    req.rd && req.addr == LPSC_OFS_SETUP_LO - 16'h0001 |=> rvalid && rdata == 16'h0000)
    else $error("unmapped word not zero");
endmodule : lpsc_bank

/* File: verif/lpsc_host.sv */
// Host model: word writes and reads on the request struct of the bank.
// Assumes the bank takes a strobe at a rising edge and answers a read one edge later.
`timescale 1ns/1ps
module lpsc_host import lpsc_pkg::*; (
  input  wire logic        clk,
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid,
  output lpsc_req_t        req
);
  // Idle lines show the inverse of the last request, so stale values never look valid
  task automatic idle();
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
  endtask : idle
  initial req = '{wr: 1'b0, rd: 1'b0, addr: 16'h0000, wdata: 16'h0000};
  // One word write; bit 44 of the transmit mask always goes out as zero
  task automatic write(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: (a == LPSC_OFS_TXM_W2) ? d & 16'hEFFF : d};
    @(posedge clk);
    idle();
  endtask : write
  // One word read; returns {rvalid, rdata} just after the edge that follows the strobe
  task automatic read(input logic [15:0] a, output logic [16:0] q);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
    @(posedge clk);
    idle();
    #1;
    q = {rvalid, rdata};
  endtask : read
endmodule : lpsc_host

/* File: verif/test_lpsc_bank.sv */
// Testbench for lpsc_bank: register sequences through the host model, checked against tables.
// Assumes a 20 MHz clock and that cfg follows a write one edge after it is taken.
`timescale 1ns/1ps
module test_lpsc_bank import lpsc_pkg::*; ();
  logic        clk, nrst, switch_pin, rvalid, switch_pressed;
  logic [15:0] rdata, w;
  logic [16:0] q;
  lpsc_req_t   req;
  lpsc_cfg_t   cfg;
  int          errors, checked, cycles;
  logic [8:0]  cyc_tab [4] = '{9'h010, 9'h020, 9'h040, 9'h100};
  logic [5:0]  pct_tab [4] = '{6'h1E, 6'h1E, 6'h14, 6'h00};
  logic [2:0]  sw_tab  [4] = '{3'h3, 3'h7, 3'h4, 3'h5};
  logic [15:0] hi_tab  [4] = '{16'hFFFF, 16'h9000, 16'h4000, 16'h23FF};
  logic [4:0]  alt_tab [4] = '{5'h1C, 5'h12, 5'h09, 5'h04};
  lpsc_bank i_lpsc_bank (.clk(clk), .nrst(nrst), .req(req), .switch_pin(switch_pin),
    .rdata(rdata), .rvalid(rvalid), .switch_pressed(switch_pressed), .cfg(cfg));
  lpsc_host i_lpsc_host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  // Read result must carry rvalid as well as the data
  task automatic chk_rd(input logic [15:0] a, input logic [15:0] exp);
    i_lpsc_host.read(a, q);
    checked++;
    if (q !== {1'b1, exp}) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, q, {1'b1, exp});
    end
  endtask : chk_rd
  task automatic chk_cfg(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cfg
  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard, far above the roughly 80 cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    switch_pin = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_cfg(cfg.lp1_cycles, 48'h10);
    chk_rd(LPSC_OFS_SETUP_HI, 16'h0000);
    // Every code of every settings field except switch enable and polarity, held at zero; unused nibble written as ones
    for (int k = 0; k < 4; k++) begin
      w = {2'b00, 2'(3 - k), 4'hF, 2'(k), k[0], k[1], 2'(k), 2'(3 - k)};
      i_lpsc_host.write(LPSC_OFS_SETTINGS, w);
      chk_rd(LPSC_OFS_SETTINGS, w & 16'hF0FF);
      chk_cfg(cfg.lp2_cycles, 48'(cyc_tab[k]));
      chk_cfg(cfg.lp1_cycles, 48'(cyc_tab[3 - k]));
      chk_cfg({cfg.main_osc, cfg.main_osc_valid}, {2'(k), k != 3});
      chk_cfg({cfg.prox_trim_code, cfg.prox_trim_pct}, {2'(3 - k), pct_tab[k]});
      chk_cfg({cfg.lp2_autoprox_en, cfg.lp1_autoprox_en}, {k[0], k[1]});
    end
    // Switch: enable, polarity, pin level
    for (int s = 0; s < 4; s++) begin
      i_lpsc_host.write(LPSC_OFS_SETTINGS, {sw_tab[s][2:1], 14'h0000});
      switch_pin <= sw_tab[s][0];
      repeat (4) @(posedge clk);
      #1;
      chk_cfg({cfg.switch_active, switch_pressed},
        {sw_tab[s][2], sw_tab[s][2] & (sw_tab[s][1] == sw_tab[s][0])});
    end
    // Alternate channel modes; low word first, pairing by address
    i_lpsc_host.write(LPSC_OFS_SETUP_LO, 16'h5A5A);
    for (int s = 0; s < 4; s++) begin
      i_lpsc_host.write(LPSC_OFS_SETUP_HI, hi_tab[s]);
      chk_rd(LPSC_OFS_SETUP_HI, hi_tab[s] & 16'hF3FF);
      chk_cfg({cfg.alt_channel_en, cfg.count_filter_en, cfg.mutual_sense, cfg.tx_shield,
        cfg.ground_unused}, alt_tab[s]);
    end
    chk_cfg(cfg.rx_mask, 48'h3FF5A5A);
    // Transmit mask across three words
    i_lpsc_host.write(LPSC_OFS_TXM_W0, 16'h1234);
    i_lpsc_host.write(LPSC_OFS_TXM_W1, 16'hABCD);
    i_lpsc_host.write(LPSC_OFS_TXM_W2, 16'hFFFF);
    chk_rd(LPSC_OFS_TXM_W2, 16'h2FFF);
    chk_cfg(cfg.tx_mask, 48'h2FFFABCD1234);
    // Unmapped word: write dropped, read gives zero, settings word untouched
    i_lpsc_host.write(16'h11C1, 16'hFFFF);
    chk_rd(16'h11C1, 16'h0000);
    chk_rd(LPSC_OFS_SETTINGS, 16'h8000);
    report_and_stop();
  end
endmodule : test_lpsc_bank
